// >>> src/mdv_unit.sv
// module: multiply/divide unit, high-performance or area-efficient build
`timescale 1ns/1ps
module mdv_unit #(
  parameter bit HIGH_PERF = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire mdv_pkg::mdv_req_t req_i,
  output logic ready_o,
  output logic busy_o,
  output logic [31:0] result_upper_reg_o,
  output logic [31:0] result_lower_reg_o,
  output mdv_pkg::mdv_gpr_t gpr_o
);

  // ****************************************************************
  // decoding
  // ****************************************************************
  function automatic logic op_signed(input mdv_pkg::mdv_op_t op);
    op_signed = (op == mdv_pkg::OP_PROD_S) || (op == mdv_pkg::OP_ACC_S) ||
                (op == mdv_pkg::OP_SUBACC_S) ||
                (op == mdv_pkg::OP_PROD_GPR) || (op == mdv_pkg::OP_QUOT_S);
  endfunction

  function automatic logic op_acc(input mdv_pkg::mdv_op_t op);
    op_acc = (op == mdv_pkg::OP_ACC_S) || (op == mdv_pkg::OP_ACC_U) ||
             (op == mdv_pkg::OP_SUBACC_S) || (op == mdv_pkg::OP_SUBACC_U);
  endfunction

  function automatic logic op_sub(input mdv_pkg::mdv_op_t op);
    op_sub = (op == mdv_pkg::OP_SUBACC_S) || (op == mdv_pkg::OP_SUBACC_U);
  endfunction

  function automatic logic op_div(input mdv_pkg::mdv_op_t op);
    op_div = (op == mdv_pkg::OP_QUOT_S) || (op == mdv_pkg::OP_QUOT_U);
  endfunction

  // radix-2 Booth step on {upper[32:0], multiplier[31:0], guard}
  function automatic logic [65:0] booth_step(input logic [65:0] p,
                                             input logic [32:0] a);
    logic [32:0] u;
    u = p[65:33];
    if (p[1:0] == 2'b01) begin
      u = p[65:33] + a;
    end else if (p[1:0] == 2'b10) begin
      u = p[65:33] - a;
    end
    booth_step = {u[32], u, p[32:1]};
  endfunction

  // one shift-subtract step on {rem[32:0], quo[31:0]}
  function automatic logic [64:0] div_step(input logic [64:0] p,
                                           input logic [32:0] d);
    logic [32:0] r2;
    logic [33:0] t;
    r2 = {p[63:32], p[31]};
    t = {1'b0, r2} - {1'b0, d};
    if (!t[33]) begin
      div_step = {t[32:0], p[30:0], 1'b1};
    end else begin
      div_step = {r2, p[30:0], 1'b0};
    end
  endfunction

  typedef enum logic [3:0] {
    S_IDLE, S_MULT, S_ACC_LO, S_ACC_HI, S_NEG, S_LOOP, S_REM, S_SGN_Q,
    S_SGN_R, S_ALIGN
  } mdv_state_t;

  mdv_state_t state_q, state_d;
  mdv_pkg::mdv_op_t op_q, op_d;
  logic [4:0] rd_q, rd_d;
  logic [65:0] p_q, p_d;
  logic [32:0] a_q, a_d;
  logic [63:0] res_q, res_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] cyc_q, cyc_d;
  logic first_q, first_d, cy_q, cy_d, nq_q, nq_d, nr_q, nr_d;
  logic fix_q, fix_d;
  logic [31:0] hi_q, lo_q, hi_d, lo_d;
  mdv_pkg::mdv_gpr_t gpr_q, gpr_d;

  // fast multiplier pipe: multiply stage (hm) and align stage (ha)
  logic hm_v_q, hm_long_q, hm_pass_q, ha_v_q;
  mdv_pkg::mdv_req_t hm_req_q;
  mdv_pkg::mdv_op_t ha_op_q;
  logic [4:0] ha_rd_q;
  logic [63:0] ha_prod_q;

  wire mdv_pkg::mdv_op_t rop = req_i.op;
  wire req_sgn = op_signed(rop);
  wire req_div = op_div(rop);
  wire req_mt = (rop == mdv_pkg::OP_WR_UPPER) ||
                (rop == mdv_pkg::OP_WR_LOWER);
  wire fsm_free = (state_q == S_IDLE) || (state_q == S_ALIGN);
  wire accept = req_i.valid && ready_o;
  wire hm_done = hm_v_q && (!hm_long_q || hm_pass_q);
  wire hp_mult_go = HIGH_PERF && accept && !req_div && !req_mt;
  wire fsm_start = accept && (req_div || (!HIGH_PERF && !req_mt));

  // ****************************************************************
  // issue handshake
  // ****************************************************************
  // a new op may enter while the previous one writes in align; the
  // previous result leaves the datapath that same cycle
  wire hm_blocks = hm_v_q && hm_long_q && !hm_pass_q;
  assign ready_o = HIGH_PERF ?
                   (fsm_free && (req_div ? !hm_v_q : !hm_blocks)) :
                   fsm_free;
  assign busy_o = !fsm_free || hm_v_q || ha_v_q;

  // ****************************************************************
  // fast multiplier
  // ****************************************************************
  // pass count depends on the second operand and the op's signedness only
  wire rt_short = req_sgn ? (&req_i.rt[31:15] || ~|req_i.rt[31:15]) :
                  ~|req_i.rt[31:16];
  wire hm_sgn = op_signed(hm_req_q.op);
  wire [65:0] hm_prod = $signed({hm_sgn & hm_req_q.rs[31], hm_req_q.rs}) *
                        $signed({hm_sgn & hm_req_q.rt[31], hm_req_q.rt});
  wire [63:0] hilo = {hi_q, lo_q};
  // carry-propagate add of the accumulate happens in align
  wire [63:0] ha_val = !op_acc(ha_op_q) ? ha_prod_q :
                       op_sub(ha_op_q) ? hilo - ha_prod_q :
                       hilo + ha_prod_q;
  wire ha_we = ha_v_q && (ha_op_q != mdv_pkg::OP_PROD_GPR);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hm_v_q <= 1'b0;
      hm_long_q <= 1'b0;
      hm_pass_q <= 1'b0;
      hm_req_q <= '0;
      ha_v_q <= 1'b0;
      ha_op_q <= mdv_pkg::OP_PROD_S;
      ha_rd_q <= 5'h00;
      ha_prod_q <= 64'h0000_0000_0000_0000;
    end else begin
      hm_v_q <= hp_mult_go || (hm_v_q && !hm_done);
      hm_pass_q <= hm_v_q && !hm_done;
      if (hp_mult_go) begin
        hm_long_q <= !rt_short;
        hm_req_q <= req_i;
      end
      ha_v_q <= hm_done;
      if (hm_done) begin
        ha_op_q <= hm_req_q.op;
        ha_rd_q <= hm_req_q.rd;
        ha_prod_q <= hm_prod[63:0];
      end
    end
  end

  // ****************************************************************
  // iterative engine: every divide, and all multiplies when small
  // ****************************************************************
  // the engine has no stall input: it keeps running whatever the
  // pipeline does, and only the handshake holds new work off
  wire [65:0] booth_nx = booth_step(p_q, a_q);
  wire [64:0] step_nx = div_step(p_q[64:0], a_q);
  wire [5:0] skip = (HIGH_PERF && first_q) ?
                    (~|p_q[31:8] ? mdv_pkg::SKIP_24 :
                     ~|p_q[31:16] ? mdv_pkg::SKIP_16 :
                     ~|p_q[31:24] ? mdv_pkg::SKIP_8 : 6'h00) : 6'h00;
  wire [63:0] corr = fix_q ? {a_q[31:0], 32'h0000_0000} :
                     64'h0000_0000_0000_0000;
  wire sub_q = op_sub(op_q);
  wire [31:0] acc_lo = sub_q ? ~res_q[31:0] : res_q[31:0];
  wire [31:0] acc_hi = sub_q ? ~res_q[63:32] : res_q[63:32];
  wire [32:0] sum_lo = {1'b0, lo_q} + {1'b0, acc_lo} + {32'h0, sub_q};
  wire div_q = op_div(op_q);

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    rd_d = rd_q;
    p_d = p_q;
    a_d = a_q;
    res_d = res_q;
    cnt_d = cnt_q;
    first_d = first_q;
    cy_d = cy_q;
    nq_d = nq_q;
    nr_d = nr_q;
    fix_d = fix_q;
    case (state_q)
      S_IDLE, S_ALIGN: begin
        state_d = S_IDLE;
        if (fsm_start) begin
          op_d = rop;
          rd_d = req_i.rd;
          cnt_d = mdv_pkg::ITER_LAST;
          first_d = 1'b1;
          nq_d = req_sgn && (req_i.rs[31] ^ req_i.rt[31]);
          nr_d = req_sgn && req_i.rs[31];
          fix_d = !req_sgn && req_i.rt[31];
          if (req_div) begin
            state_d = S_NEG;
            p_d = {34'h0, req_i.rs};
            a_d = (req_sgn && req_i.rt[31]) ? {1'b0, -req_i.rt} :
                  {1'b0, req_i.rt};
          end else begin
            state_d = S_MULT;
            p_d = {33'h0, req_i.rt, 1'b0};
            a_d = {req_sgn & req_i.rs[31], req_i.rs};
          end
        end
      end
      S_MULT: begin
        p_d = booth_nx;
        cnt_d = cnt_q - 6'h01;
        if (cnt_q == 6'h00) begin
          res_d = booth_nx[64:1] + corr;
          state_d = op_acc(op_q) ? S_ACC_LO : S_ALIGN;
        end
      end
      S_ACC_LO: begin
        res_d[31:0] = sum_lo[31:0];
        cy_d = sum_lo[32];
        state_d = S_ACC_HI;
      end
      S_ACC_HI: begin
        res_d[63:32] = hi_q + acc_hi + {31'h0, cy_q};
        state_d = S_ALIGN;
      end
      S_NEG: begin
        // spent even for a positive dividend
        if (nr_q) begin
          p_d[31:0] = -p_q[31:0];
        end
        state_d = S_LOOP;
      end
      S_LOOP: begin
        p_d = {1'b0, step_nx << skip};
        cnt_d = cnt_q - 6'h01 - skip;
        first_d = 1'b0;
        if (cnt_q == 6'h00) begin
          if (HIGH_PERF) begin
            state_d = (nq_q || nr_q) ? S_REM : S_ALIGN;
          end else begin
            state_d = nq_q ? S_SGN_Q : nr_q ? S_SGN_R : S_ALIGN;
          end
        end
      end
      S_REM: begin
        // restoring steps never leave a negative remainder, so the
        // cycle only keeps the documented cadence
        state_d = S_SGN_Q;
      end
      S_SGN_Q: begin
        if (nq_q) begin
          p_d[31:0] = -p_q[31:0];
        end
        if (HIGH_PERF && nr_q) begin
          p_d[63:32] = -p_q[63:32];
        end
        state_d = (!HIGH_PERF && nr_q) ? S_SGN_R : S_ALIGN;
      end
      S_SGN_R: begin
        p_d[63:32] = -p_q[63:32];
        state_d = S_ALIGN;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  // cycles spent since the op left issue, held through align
  assign cyc_d = fsm_start ? 6'h00 : (fsm_free ? cyc_q : cyc_q + 6'h01);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= S_IDLE;
      op_q <= mdv_pkg::OP_PROD_S;
      rd_q <= 5'h00;
      p_q <= '0;
      a_q <= '0;
      res_q <= 64'h0000_0000_0000_0000;
      cnt_q <= 6'h00;
      cyc_q <= 6'h00;
      first_q <= 1'b0;
      cy_q <= 1'b0;
      nq_q <= 1'b0;
      nr_q <= 1'b0;
      fix_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      rd_q <= rd_d;
      p_q <= p_d;
      a_q <= a_d;
      res_q <= res_d;
      cnt_q <= cnt_d;
      cyc_q <= cyc_d;
      first_q <= first_d;
      cy_q <= cy_d;
      nq_q <= nq_d;
      nr_q <= nr_d;
      fix_q <= fix_d;
    end
  end

  // ****************************************************************
  // result registers and register-file write
  // ****************************************************************
  wire in_align = state_q == S_ALIGN;
  wire fsm_gpr = in_align && (op_q == mdv_pkg::OP_PROD_GPR);
  wire fsm_we = in_align && !fsm_gpr;
  wire [63:0] fsm_val = div_q ? p_q[63:0] : res_q;
  wire wr_hi = accept && (rop == mdv_pkg::OP_WR_UPPER);
  wire wr_lo = accept && (rop == mdv_pkg::OP_WR_LOWER);

  // an explicit write is younger than any op finishing, so it wins
  assign hi_d = wr_hi ? req_i.rs : fsm_we ? fsm_val[63:32] :
                ha_we ? ha_val[63:32] : hi_q;
  assign lo_d = wr_lo ? req_i.rs : fsm_we ? fsm_val[31:0] :
                ha_we ? ha_val[31:0] : lo_q;
  assign gpr_d.we = fsm_gpr || (ha_v_q && !ha_we);
  assign gpr_d.addr = fsm_gpr ? rd_q : ha_rd_q;
  assign gpr_d.data = fsm_gpr ? res_q[31:0] : ha_val[31:0];

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      hi_q <= mdv_pkg::HILO_RST;
      lo_q <= mdv_pkg::HILO_RST;
      gpr_q <= '0;
    end else begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      gpr_q <= gpr_d;
    end
  end

  assign result_upper_reg_o = hi_q;
  assign result_lower_reg_o = lo_q;
  assign gpr_o = gpr_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  sequence short_flow;
    hm_v_q && !hm_long_q ##1 ha_v_q && !hm_pass_q;
  endsequence
  sequence long_flow;
    hm_v_q [*2] ##1 ha_v_q;
  endsequence

  a_short_mult_flow: assert property (
    hp_mult_go && rt_short |=> short_flow)
    else $error("short multiply did not take one clock per stage");
  a_long_mult_flow: assert property (
    hp_mult_go && !rt_short |=> long_flow)
    else $error("full multiply did not hold multiply stage two clocks");
  a_div_negate: assert property (
    fsm_start && req_div |=> state_q == S_NEG ##1 state_q == S_LOOP)
    else $error("divide did not spend its negate cycle");
  a_fast_div_bound: assert property (
    HIGH_PERF && in_align && div_q |-> cyc_q <= mdv_pkg::HP_DIV_MAX)
    else $error("fast divide loop ran too long");
  a_early_skip: assert property (
    HIGH_PERF && state_q == S_LOOP && first_q && ~|p_q[31:8]
    |=> cnt_q == mdv_pkg::ITER_LAST - mdv_pkg::SKIP_24 - 6'h01)
    else $error("early-in skip not taken");
  a_rem_adjust: assert property (
    HIGH_PERF && state_q == S_LOOP && cnt_q == 6'h00 && (nq_q || nr_q)
    |=> state_q == S_REM ##1 state_q == S_SGN_Q ##1 in_align)
    else $error("remainder adjust or sign adjust missing");
  a_small_mult_len: assert property (
    !HIGH_PERF && in_align && !div_q && !op_acc(op_q)
    |-> cyc_q == mdv_pkg::MULT_CYC)
    else $error("small multiply not 32 cycles");
  a_small_macc_len: assert property (
    !HIGH_PERF && in_align && op_acc(op_q) |-> cyc_q == mdv_pkg::MACC_CYC)
    else $error("small accumulate not 34 cycles");
  a_small_div_len: assert property (
    !HIGH_PERF && in_align && div_q
    |-> cyc_q == mdv_pkg::DIV_CYC + 6'(nq_q) + 6'(nr_q))
    else $error("small divide length wrong for operand signs");
  a_gpr_write: assert property (
    fsm_gpr |=> gpr_o.we && gpr_o.addr == $past(rd_q))
    else $error("register file write missing in writeback");
  a_div_holds_off: assert property (
    !fsm_free |-> !ready_o && busy_o)
    else $error("request accepted while a divide was active");

endmodule

// >>> src/mdv_pkg.sv
// package: operations, carriers and constants of the multiply/divide unit
package mdv_pkg;

  // ****************************************************************
  // widths and counts
  // ****************************************************************
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SHORT_W = 16;
  localparam logic [5:0] ITER_LAST = 6'h1F;
  localparam logic [5:0] SKIP_8 = 6'h07;
  localparam logic [5:0] SKIP_16 = 6'h0F;
  localparam logic [5:0] SKIP_24 = 6'h17;
  localparam logic [5:0] MULT_CYC = 6'h20;
  localparam logic [5:0] MACC_CYC = 6'h22;
  localparam logic [5:0] DIV_CYC = 6'h21;
  localparam logic [5:0] HP_DIV_MAX = 6'h23;
  localparam logic [31:0] HILO_RST = 32'h0000_0000;

  // ****************************************************************
  // operations and carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_PROD_S, OP_PROD_U, OP_ACC_S, OP_ACC_U, OP_SUBACC_S, OP_SUBACC_U,
    OP_PROD_GPR, OP_QUOT_S, OP_QUOT_U, OP_WR_UPPER, OP_WR_LOWER
  } mdv_op_t;

  typedef struct packed {
    logic valid;
    mdv_op_t op;
    logic [31:0] rs;
    logic [31:0] rt;
    logic [4:0] rd;
  } mdv_req_t;

  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [31:0] data;
  } mdv_gpr_t;

endpackage

// >>> bench/mdv_pipe_model.sv
// integer pipeline model: issues unit requests and holds them until taken
`timescale 1ns/1ps
module mdv_pipe_model (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic go_i,
  input wire mdv_pkg::mdv_req_t cmd_i,
  input wire logic [1:0] cnt_i,
  input wire logic ready_i,
  output mdv_pkg::mdv_req_t req_o,
  output logic taken_o
);
  logic [1:0] left_q;
  // the request may repeat cnt_i times back to back, to probe repeat rates
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      req_o <= '0;
      left_q <= 2'h0;
      taken_o <= 1'b0;
    end else begin
      taken_o <= req_o.valid && ready_i;
      if (go_i) begin
        req_o <= cmd_i;
        req_o.valid <= 1'b1;
        left_q <= cnt_i;
      end else if (req_o.valid && ready_i) begin
        left_q <= left_q - 2'h1;
        if (left_q == 2'h1) begin
          // released operands never show the last value
          req_o.valid <= 1'b0;
          req_o.rs <= ~req_o.rs;
          req_o.rt <= ~req_o.rt;
        end
      end
    end
  end
  // a refused request is simply held until ready_i is seen high
endmodule

// >>> bench/multiply_divide_unit_bench.sv
// testbench: both unit builds side by side, driven by pipeline models
`timescale 1ns/1ps
module multiply_divide_unit_bench;
  typedef struct packed {
    mdv_pkg::mdv_op_t op;
    logic [31:0] rs;
    logic [31:0] rt;
    logic [31:0] hi;
    logic [31:0] lo;
    int lat_s;
    int lat_f;
  } mdv_case_t;
  // ****************************************************************
  // sequence of operations; results chain through the result registers
  // ****************************************************************
  localparam mdv_case_t TBL [17] = '{
    '{mdv_pkg::OP_WR_UPPER, 32'h0000_0001, 32'h0, 32'h1, 32'h0, 1, 1},
    '{mdv_pkg::OP_WR_LOWER, 32'hFFFF_FFFE, 32'h0, 32'h1, 32'hFFFF_FFFE,
      1, 1},
    '{mdv_pkg::OP_ACC_U, 32'h3, 32'h5, 32'h2, 32'hD, 35, 2},
    '{mdv_pkg::OP_SUBACC_U, 32'h2, 32'h3, 32'h2, 32'h7, 35, 2},
    '{mdv_pkg::OP_ACC_S, 32'hFFFF_FFFF, 32'h2, 32'h2, 32'h5, 35, 2},
    '{mdv_pkg::OP_SUBACC_S, 32'hFFFF_FFFF, 32'h0001_0000, 32'h2,
      32'h0001_0005, 35, 3},
    '{mdv_pkg::OP_PROD_S, 32'h0001_2345, 32'hFFFF_FFFE, 32'hFFFF_FFFF,
      32'hFFFD_B976, 33, 2},
    '{mdv_pkg::OP_PROD_U, 32'hFFFF_FFFF, 32'h0002_0000, 32'h0001_FFFF,
      32'hFFFE_0000, 33, 3},
    '{mdv_pkg::OP_QUOT_U, 32'h64, 32'h7, 32'h2, 32'hE, 34, 0},
    '{mdv_pkg::OP_QUOT_S, 32'hFFFF_FF9C, 32'h7, 32'hFFFF_FFFE,
      32'hFFFF_FFF2, 36, 0},
    '{mdv_pkg::OP_QUOT_S, 32'h64, 32'hFFFF_FFF9, 32'h2, 32'hFFFF_FFF2,
      35, 0},
    '{mdv_pkg::OP_QUOT_S, 32'h64, 32'h7, 32'h2, 32'hE, 34, 0},
    '{mdv_pkg::OP_PROD_GPR, 32'h3, 32'h4, 32'h0, 32'hC, 33, 2},
    '{mdv_pkg::OP_QUOT_U, 32'hFF, 32'h1, 32'h0, 32'hFF, 34, 0},
    '{mdv_pkg::OP_QUOT_U, 32'hFFFF, 32'h1, 32'h0, 32'hFFFF, 34, 0},
    '{mdv_pkg::OP_QUOT_U, 32'hFF_FFFF, 32'h1, 32'h0, 32'hFF_FFFF, 34, 0},
    '{mdv_pkg::OP_QUOT_U, 32'hFFFF_FFFF, 32'h1, 32'h0, 32'hFFFF_FFFF, 34, 0}
  };
  logic ref_clk_i;
  logic srst_i;
  logic go [2];
  logic [1:0] cnt [2];
  logic ready [2];
  logic busy [2];
  logic taken [2];
  logic [31:0] hi [2];
  logic [31:0] lo [2];
  mdv_pkg::mdv_req_t cmd [2];
  mdv_pkg::mdv_req_t req [2];
  mdv_pkg::mdv_gpr_t gpr [2];
  int fail_count = 0;
  int checks_done = 0;
  int lat_tab [2][17];
  // index 0 is the area-efficient build, index 1 the fast one
  for (genvar v = 0; v < 2; v++) begin : g_v
    mdv_pipe_model PIPE (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .go_i(go[v]), .cmd_i(cmd[v]), .cnt_i(cnt[v]), .ready_i(ready[v]),
      .req_o(req[v]), .taken_o(taken[v]));
    mdv_unit #(.HIGH_PERF(v)) DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
      .req_i(req[v]), .ready_o(ready[v]), .busy_o(busy[v]),
      .result_upper_reg_o(hi[v]), .result_lower_reg_o(lo[v]),
      .gpr_o(gpr[v]));
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // load the pipeline model; returns once the unit has taken the request
  task automatic issue(input int v, input mdv_case_t c, input int n);
    @(posedge ref_clk_i);
    cmd[v] <= '{1'b1, c.op, c.rs, c.rt, 5'h05};
    cnt[v] <= 2'(n);
    go[v] <= 1'b1;
    @(posedge ref_clk_i);
    go[v] <= 1'b0;
    for (int k = 0; k < 80 && taken[v] !== 1'b1; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    chk(taken[v] === 1'b1, "request never taken");
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    for (int v = 0; v < 2; v++) begin
      chk(ready[v] === 1'b1 && busy[v] === 1'b0, "idle flags after reset");
      chk(hi[v] === 32'h0 && lo[v] === 32'h0 && gpr[v] === '0,
        "result values after reset");
    end
    $display("test reset done");
  endtask
  task automatic t_table();
    bit hit;
    int n;
    int ex;
    mdv_case_t c;
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 17; i++) begin
        c = TBL[i];
        issue(v, c, 1);
        hit = 0;
        for (n = 0; n < 60 && !hit; n++) begin
          @(posedge ref_clk_i);
          #1;
          if (n == 0 && c.op < mdv_pkg::OP_WR_UPPER) begin
            chk(busy[v] === 1'b1, "busy missing while running");
          end
          if (c.op == mdv_pkg::OP_PROD_GPR) begin
            hit = gpr[v].we === 1'b1 && gpr[v].addr === 5'h05 &&
              gpr[v].data === c.lo;
          end else begin
            hit = hi[v] === c.hi && lo[v] === c.lo;
          end
        end
        lat_tab[v][i] = n;
        chk(hit, "wrong result values");
        ex = v ? c.lat_f : c.lat_s;
        if (ex != 0) begin
          chk(n == ex, "wrong result latency");
        end
      end
    end
    $display("test table done");
  endtask
  task automatic t_early();
    int f [17];
    f = lat_tab[1];
    chk(f[13] < f[14] && f[14] < f[15] && f[15] < f[16],
      "fast divide not shortened by zero upper bits");
    chk(f[16] <= 36 && f[13] >= 9, "fast divide length off");
    chk(f[11] < f[9], "positive divide not shorter");
    $display("test early done");
  endtask
  task automatic rep(input int v, input mdv_pkg::mdv_op_t op,
      input logic [31:0] rs, input logic [31:0] rt, input int ex);
    int n;
    issue(v, '{op, rs, rt, 32'h0, 32'h0, 0, 0}, 2);
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk_i);
      #1;
      if (taken[v] === 1'b1) break;
    end
    chk(n + 1 == ex, "wrong repeat rate");
    for (int k = 0; k < 80 && busy[v] !== 1'b0; k++) begin
      @(posedge ref_clk_i);
      #1;
    end
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic t_repeat();
    rep(0, mdv_pkg::OP_PROD_S, 32'h5, 32'h7, 33);
    rep(0, mdv_pkg::OP_ACC_S, 32'h5, 32'h7, 35);
    rep(0, mdv_pkg::OP_QUOT_U, 32'h64, 32'h7, 34);
    rep(0, mdv_pkg::OP_QUOT_S, 32'hFFFF_FF9C, 32'hFFFF_FFF9, 35);
    rep(0, mdv_pkg::OP_QUOT_S, 32'hFFFF_FF9C, 32'h7, 36);
    rep(1, mdv_pkg::OP_PROD_U, 32'hFFFF_FFFF, 32'h7, 1);
    rep(1, mdv_pkg::OP_PROD_U, 32'h7, 32'hFFFF_FFFF, 2);
    $display("test repeat done");
  endtask
  initial begin
    srst_i = 1'b1;
    for (int v = 0; v < 2; v++) begin
      go[v] = 1'b0;
      cnt[v] = 2'h0;
      cmd[v] = '0;
    end
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    t_reset();
    t_table();
    t_early();
    t_repeat();
    end_of_test();
  end
  // whole run is under two thousand cycles; this bound only catches a hang
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule
